//--- lsoc_pkg.sv
// Package of constants and types for the light screen output control block.
//
// Contract
// - The unit is configured for either automatic restart or manual reset, which decides whether run starts unaided.
// - In automatic restart the outputs turn on after power-up only once self-test and sync pass and all beams are clear.
// - In automatic restart the outputs turn back on unaided once all beams are clear again after a blockage.
// - In manual reset the outputs stay off after power-up, beams clear or not, until a manual reset arrives.
// - Any blocked beam turns the outputs off so the machine sees a stop.
// - One external input serves reset from latch or lockout, external test, and external device checking; device checking uses external_device_check.
// - Operating the shared input while running with outputs on is a test request.
// - Operating the shared input while latched or locked out is a reset request.
// - Beam-blocked to outputs-off time is at most 11 ms for 8 beams up to 29 ms for 96 beams, per 8-beam step.
// - A failure found by the periodic test sends a stop and enters lockout, left only through the reset procedure.
package lsoc_pkg;

    // Register byte offsets on the AXI4-Lite slave.
    localparam logic [7:0] ADDR_CTRL   = 8'h00;
    localparam logic [7:0] ADDR_STATUS = 8'h04;
    localparam logic [7:0] ADDR_IRQ_ST = 8'h08;
    localparam logic [7:0] ADDR_IRQ_MK = 8'h0C;

    // Control register fields.
    localparam int CTRL_MANUAL_BIT = 0;
    localparam int CTRL_CHECK_BIT  = 1;
    localparam logic [1:0] CTRL_RESET = 2'h3;

    // Interrupt event bit positions.
    localparam int EV_TRIP = 0;
    localparam int EV_LOCK = 1;
    localparam int EV_ON   = 2;
    localparam int EV_W    = 3;

    // AXI responses.
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // Timing.
    localparam int CLK_HZ          = 50_000_000;
    localparam int TEST_WINDOW_US  = 1000;
    localparam int TEST_WINDOW_CYC = TEST_WINDOW_US * (CLK_HZ / 1_000_000);
    localparam int EDM_SETTLE_US   = 300;
    localparam int EDM_SETTLE_CYC  = EDM_SETTLE_US * (CLK_HZ / 1_000_000);
    localparam int BEAMS_PER_STEP  = 8;

    // Output control states.
    typedef enum logic [2:0] {
        ST_POWERUP,
        ST_WAIT_RESET,
        ST_RUN,
        ST_TEST,
        ST_LOCKOUT
    } lsoc_state_t;

endpackage

//--- lsoc_edge.sv
// Rising-edge detector for the shared external input.
module lsoc_edge
(
    input  wire logic clk,
    input  wire logic nrst,
    input  wire logic level,
    output logic      rise
);
    logic last_r;

    // Remembers the previous level to mark a press as a single pulse.
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
            last_r <= 1'b0;
        else
            last_r <= level;
    end

    assign rise = level & ~last_r;
endmodule

//--- lsoc_top.sv
// Output control state logic of a light screen receiver with AXI4-Lite registers.
module lsoc_top
    import lsoc_pkg::*;
#(
    parameter int NUM_BEAMS      = 8,
    parameter int TEST_WINDOW    = lsoc_pkg::TEST_WINDOW_CYC,
    parameter int EDM_SETTLE     = lsoc_pkg::EDM_SETTLE_CYC
)
(
    input  wire logic                 clk,
    input  wire logic                 nrst,
    input  wire logic [NUM_BEAMS-1:0] beam_clear,
    input  wire logic                 self_test_ok,
    input  wire logic                 sync_ok,
    input  wire logic                 ext_input,
    input  wire logic                 external_device_check,
    input  wire logic                 test_fail,
    output logic                      safety_switch_outputs,
    output logic                      test_active,
    output logic                      irq,
    input  wire logic [7:0]           s_axi_awaddr,
    input  wire logic                 s_axi_awvalid,
    output logic                      s_axi_awready,
    input  wire logic [31:0]          s_axi_wdata,
    input  wire logic [3:0]           s_axi_wstrb,
    input  wire logic                 s_axi_wvalid,
    output logic                      s_axi_wready,
    output logic [1:0]                s_axi_bresp,
    output logic                      s_axi_bvalid,
    input  wire logic                 s_axi_bready,
    input  wire logic [7:0]           s_axi_araddr,
    input  wire logic                 s_axi_arvalid,
    output logic                      s_axi_arready,
    output logic [31:0]               s_axi_rdata,
    output logic [1:0]                s_axi_rresp,
    output logic                      s_axi_rvalid,
    input  wire logic                 s_axi_rready
);
    import lsoc_pkg::*;

    // Response time budget: 11 ms at 8 beams plus about 1.6 ms per further 8 beams, as a cycle count.
    localparam int RESP_TIME_US  = 11000 + ((NUM_BEAMS / BEAMS_PER_STEP) - 1) * 18000 / 11;
    localparam int RESP_CYC      = RESP_TIME_US * (CLK_HZ / 1_000_000);

    lsoc_state_t   state_r;
    lsoc_state_t   state_nxt;
    logic [1:0]    ctrl_r;
    logic [EV_W-1:0] irq_st_r;
    logic [EV_W-1:0] irq_mk_r;
    logic [31:0]   tcnt_r;
    logic          press;
    logic          all_clear;
    logic          manual;
    logic          edm_ok;
    logic          aw_hold_r;
    logic          w_hold_r;
    logic [7:0]    awaddr_r;
    logic [31:0]   wdata_r;
    logic [3:0]    wstrb_r;
    logic          do_write;
    logic          rd_status;
    logic [EV_W-1:0] ev;

    // A press of the shared input is seen as one pulse.
    lsoc_edge u_edge
    (
        .clk   (clk),
        .nrst  (nrst),
        .level (ext_input),
        .rise  (press)
    );

    assign all_clear = &beam_clear;
    assign manual    = ctrl_r[CTRL_MANUAL_BIT];
    // Contact pair reads closed when outputs are off; disabled check always passes.
    assign edm_ok    = !ctrl_r[CTRL_CHECK_BIT] || (external_device_check == !safety_switch_outputs);

    // Next state of the output control machine.
    always_comb
    begin
        state_nxt = state_r;
        case (state_r)
            ST_POWERUP:
                if (self_test_ok && sync_ok && all_clear)
                    state_nxt = manual ? ST_WAIT_RESET : ST_RUN;
            ST_WAIT_RESET:
                if (press && all_clear && edm_ok)
                    state_nxt = ST_RUN;
            ST_RUN:
                if (!all_clear)
                    state_nxt = manual ? ST_WAIT_RESET : ST_POWERUP;
                else if (press)
                    state_nxt = ST_TEST;
            ST_TEST:
                if (test_fail || (tcnt_r >= 32'(EDM_SETTLE) && !edm_ok))
                    state_nxt = ST_LOCKOUT;
                else if (tcnt_r >= 32'(TEST_WINDOW - 1))
                    state_nxt = all_clear ? ST_RUN : (manual ? ST_WAIT_RESET : ST_POWERUP);
            ST_LOCKOUT:
                if (press && !test_fail)
                    state_nxt = manual ? ST_WAIT_RESET : ST_POWERUP;
            default:
                state_nxt = ST_LOCKOUT;
        endcase
    end

    // State register; a blocked beam acts in one cycle, well inside the budget.
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
            state_r <= ST_POWERUP;
        else
            state_r <= state_nxt;
    end

    // Test window counter, restarted on each entry to test.
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
            tcnt_r <= 32'h0;
        else if (state_r != ST_TEST)
            tcnt_r <= 32'h0;
        else
            tcnt_r <= tcnt_r + 32'h1;
    end

    // Outputs are registered and on only in run with every beam clear.
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            safety_switch_outputs <= 1'b0;
            test_active           <= 1'b0;
        end
        else
        begin
            safety_switch_outputs <= (state_nxt == ST_RUN) && all_clear;
            test_active           <= (state_nxt == ST_TEST);
        end
    end

    // Events: trip, lockout entry, outputs turning on.
    assign ev[EV_TRIP] = (state_r == ST_RUN) && !all_clear;
    assign ev[EV_LOCK] = (state_r != ST_LOCKOUT) && (state_nxt == ST_LOCKOUT);
    assign ev[EV_ON]   = (state_r != ST_RUN) && (state_nxt == ST_RUN);

    // AXI write: address and data captured in either order.
    assign s_axi_awready = !aw_hold_r && !s_axi_bvalid;
    assign s_axi_wready  = !w_hold_r && !s_axi_bvalid;
    assign do_write      = aw_hold_r && w_hold_r && !s_axi_bvalid;

    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            aw_hold_r <= 1'b0;
            w_hold_r  <= 1'b0;
            awaddr_r  <= 8'h00;
            wdata_r   <= 32'h0;
            wstrb_r   <= 4'h0;
        end
        else
        begin
            if (s_axi_awvalid && s_axi_awready)
            begin
                aw_hold_r <= 1'b1;
                awaddr_r  <= s_axi_awaddr;
            end
            else if (do_write)
                aw_hold_r <= 1'b0;
            if (s_axi_wvalid && s_axi_wready)
            begin
                w_hold_r <= 1'b1;
                wdata_r  <= s_axi_wdata;
                wstrb_r  <= s_axi_wstrb;
            end
            else if (do_write)
                w_hold_r <= 1'b0;
        end
    end

    // Write response, SLVERR for unmapped or read-only addresses.
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= RESP_OKAY;
        end
        else if (do_write)
        begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= (awaddr_r == ADDR_CTRL || awaddr_r == ADDR_IRQ_MK) ? RESP_OKAY : RESP_SLVERR;
        end
        else if (s_axi_bready)
            s_axi_bvalid <= 1'b0;
    end

    // Control and mask registers; only byte lane 0 carries bits.
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            ctrl_r   <= CTRL_RESET;
            irq_mk_r <= '0;
        end
        else if (do_write && wstrb_r[0])
        begin
            if (awaddr_r == ADDR_CTRL)
                ctrl_r <= wdata_r[1:0];
            if (awaddr_r == ADDR_IRQ_MK)
                irq_mk_r <= wdata_r[EV_W-1:0];
        end
    end

    // AXI read: one outstanding read, answered the cycle after the address.
    assign s_axi_arready = !s_axi_rvalid;
    assign rd_status     = s_axi_arvalid && s_axi_arready && (s_axi_araddr == ADDR_IRQ_ST);

    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata  <= 32'h0;
            s_axi_rresp  <= RESP_OKAY;
        end
        else if (s_axi_arvalid && s_axi_arready)
        begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp  <= RESP_OKAY;
            case (s_axi_araddr)
                ADDR_CTRL:   s_axi_rdata <= {30'h0, ctrl_r};
                ADDR_STATUS: s_axi_rdata <= {26'h0, test_active, safety_switch_outputs, 1'b0, 3'(state_r)};
                ADDR_IRQ_ST: s_axi_rdata <= {29'h0, irq_st_r};
                ADDR_IRQ_MK: s_axi_rdata <= {29'h0, irq_mk_r};
                default:
                begin
                    s_axi_rdata <= 32'h0;
                    s_axi_rresp <= RESP_SLVERR;
                end
            endcase
        end
        else if (s_axi_rready)
            s_axi_rvalid <= 1'b0;
    end

    // Sticky events; a read clears them but a new event in that cycle survives.
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
            irq_st_r <= '0;
        else
            irq_st_r <= (rd_status ? '0 : irq_st_r) | ev;
    end

    assign irq = |(irq_st_r & irq_mk_r);

    // Checks that guard the control behaviour.
    property p_block_off;
        @(posedge clk) disable iff (!nrst) !all_clear |=> !safety_switch_outputs;
    endproperty
    a_block_off: assert property (p_block_off) else $error("Outputs on with a blocked beam.");

    property p_resp_time;
        @(posedge clk) disable iff (!nrst) $fell(all_clear) |-> ##[0:1] !safety_switch_outputs;
    endproperty
    a_resp_time: assert property (p_resp_time) else $error("Outputs slow to turn off.");

    property p_auto_on;
        @(posedge clk) disable iff (!nrst)
            (state_r == ST_POWERUP && !manual && self_test_ok && sync_ok && all_clear) |=> safety_switch_outputs;
    endproperty
    a_auto_on: assert property (p_auto_on) else $error("Automatic restart failed to turn on.");

    property p_auto_restart;
        @(posedge clk) disable iff (!nrst)
            (state_r == ST_POWERUP && !manual && $past(state_r) == ST_RUN && self_test_ok && sync_ok && all_clear)
            |=> safety_switch_outputs;
    endproperty
    a_auto_restart: assert property (p_auto_restart) else $error("No restart after clear.");

    property p_manual_hold;
        @(posedge clk) disable iff (!nrst) (state_r == ST_WAIT_RESET && !press) |=> !safety_switch_outputs;
    endproperty
    a_manual_hold: assert property (p_manual_hold) else $error("Outputs on without reset.");

    property p_manual_trip;
        @(posedge clk) disable iff (!nrst) (state_r == ST_RUN && manual && !all_clear) |=> state_r == ST_WAIT_RESET;
    endproperty
    a_manual_trip: assert property (p_manual_trip) else $error("Manual trip not latched.");

    sequence s_run_press;
        state_r == ST_RUN && all_clear && press;
    endsequence
    property p_test_req;
        @(posedge clk) disable iff (!nrst) s_run_press |=> test_active ##0 state_r == ST_TEST;
    endproperty
    a_test_req: assert property (p_test_req) else $error("Press in run did not test.");

    property p_reset_req;
        @(posedge clk) disable iff (!nrst) (state_r == ST_LOCKOUT && press && !test_fail) |=> state_r != ST_LOCKOUT;
    endproperty
    a_reset_req: assert property (p_reset_req) else $error("Press in lockout did not reset.");

    property p_lock_stay;
        @(posedge clk) disable iff (!nrst)
            (state_r == ST_TEST && test_fail) |=> (state_r == ST_LOCKOUT && !safety_switch_outputs) [*2];
    endproperty
    a_lock_stay: assert property (p_lock_stay) else $error("Test failure did not lock out.");
endmodule

//--- lsoc_machine.sv
// Model of the guarded machine's control elements and the operator switch.
module lsoc_machine
(
    input  wire logic clk,
    input  wire logic nrst,
    input  wire logic safety_switch_outputs,
    input  wire logic fault,
    output logic      ext_input,
    output logic      external_device_check
);
    timeunit 1ns;
    timeprecision 1ps;

    logic relay_r;

    // The relays follow the outputs one cycle late, as a real contactor never drops at once.
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
            relay_r <= 1'b0;
        else
            relay_r <= safety_switch_outputs;
    end

    // Closed and open contacts wired series-parallel; a welded contact shows through fault.
    assign external_device_check = ~relay_r ^ fault;

    // One operator press, held three cycles so that it reads as a deliberate act.
    task automatic press();
        @(posedge clk);
        ext_input <= 1'b1;
        repeat (3) @(posedge clk);
        ext_input <= 1'b0;
    endtask

    // The switch rests released at power-up.
    initial ext_input = 1'b0;
endmodule

//--- light_screen_output_control_test.sv
// Self-checking testbench of the light screen output control block.
module light_screen_output_control_test import lsoc_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;

    logic        clk, nrst, self_test_ok, sync_ok, test_fail, fault, ext_input, edc;
    logic        outs, test_active, irq, awvalid, awready, wvalid, wready, bvalid, bready;
    logic        arvalid, arready, rvalid, rready;
    logic [7:0]  beam_clear, awaddr, araddr;
    logic [31:0] wdata, rdata, rd;
    logic [3:0]  wstrb;
    logic [1:0]  bresp, rresp, rs;
    int          err_total, checks, exp_on, exp_irq;

    // Free-running 50 MHz clock.
    always #10 clk = ~clk;

    lsoc_top #(.NUM_BEAMS(8), .TEST_WINDOW(20), .EDM_SETTLE(5)) dut (.clk(clk), .nrst(nrst),
        .beam_clear(beam_clear), .self_test_ok(self_test_ok), .sync_ok(sync_ok), .ext_input(ext_input),
        .external_device_check(edc), .test_fail(test_fail), .safety_switch_outputs(outs),
        .test_active(test_active), .irq(irq), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
        .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));

    lsoc_machine partner (.clk(clk), .nrst(nrst), .safety_switch_outputs(outs), .fault(fault),
        .ext_input(ext_input), .external_device_check(edc));

    // Compares one value and counts it.
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp)
        begin
            err_total++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    // Prints the counts and the verdict, then stops.
    task automatic results();
        $display("checks=%0d mismatches=%0d", checks, err_total);
        if (err_total == 0 && checks > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    // One write; response code 1 is never expected, so it doubles as "no answer yet".
    task automatic axw(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
        logic [1:0] got;
        got = 2'h1;
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        while (got === 2'h1)
        begin
            @(posedge clk);
            if (awvalid && awready)
                awvalid <= 1'b0;
            if (wvalid && wready)
                wvalid <= 1'b0;
            if (bvalid)
            begin
                got = bresp;
                bready <= 1'b0;
            end
        end
        chk(got, er);
    endtask

    // One read, returning data and response; an edge first keeps rready from being set twice in one step.
    task automatic axr(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        r = 2'h1;
        d = 32'h0;
        @(posedge clk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        while (r === 2'h1)
        begin
            @(posedge clk);
            if (arvalid && arready)
                arvalid <= 1'b0;
            if (rvalid)
            begin
                d = rdata;
                r = rresp;
                rready <= 1'b0;
            end
        end
    endtask

    // Advances the model to state s, tracks events, then checks status and outputs.
    task automatic st(input int s);
        int on;
        // The outputs are off during a test; only a blockage out of run counts as a trip.
        on = (s == 2);
        if (on && !exp_on)
            exp_irq |= 4;
        if (!on && exp_on && s < 3)
            exp_irq |= 1;
        exp_on = on;
        repeat (4) @(posedge clk);
        axr(ADDR_STATUS, rd, rs);
        chk(rd, {26'h0, s == 3, on == 1, 1'b0, s[2:0]});
        chk(outs, on == 1);
        chk(test_active, s == 3);
    endtask

    // Main sequence.
    initial
    begin
        clk = 1'b0;
        nrst = 1'b0;
        {beam_clear, self_test_ok, sync_ok, test_fail, fault} = '0;
        {awaddr, awvalid, wdata, wvalid, bready, araddr, arvalid, rready} = '0;
        wstrb = 4'hF;
        void'($urandom(32'hC1AB));
        repeat (16) @(posedge clk);
        nrst <= 1'b1;
        @(posedge clk);
        axr(ADDR_CTRL, rd, rs);
        chk(rd, 32'h3);
        st(0);
        axr(8'h10, rd, rs);
        chk(rd, 32'h0);
        chk(rs, RESP_SLVERR);
        axw(ADDR_STATUS, 32'h0, RESP_SLVERR);
        $display("done: reset and map");
        beam_clear <= 8'hFF;
        self_test_ok <= 1'b1;
        sync_ok <= 1'b1;
        st(1);
        fault <= 1'b1;
        partner.press();
        st(1);
        fault <= 1'b0;
        partner.press();
        st(2);
        $display("done: manual start");
        axw(ADDR_IRQ_MK, 32'h7, RESP_OKAY);
        axr(ADDR_IRQ_ST, rd, rs);
        exp_irq = 0;
        beam_clear <= ~(8'h01 << ($urandom % 8));
        @(posedge clk);
        #1 chk(outs, 1'b0);
        st(1);
        chk(irq, 1'b1);
        beam_clear <= 8'hFF;
        st(1);
        axw(ADDR_IRQ_MK, 32'h0, RESP_OKAY);
        @(negedge clk) chk(irq, 1'b0);
        @(posedge clk);
        axr(ADDR_IRQ_ST, rd, rs);
        chk(rd, exp_irq);
        axw(ADDR_IRQ_MK, 32'h7, RESP_OKAY);
        @(negedge clk) chk(irq, 1'b0);
        @(posedge clk);
        partner.press();
        st(2);
        $display("done: manual trip and interrupts");
        partner.press();
        st(3);
        repeat (30) @(posedge clk);
        st(2);
        partner.press();
        test_fail <= 1'b1;
        st(4);
        axr(ADDR_IRQ_ST, rd, rs);
        chk(rd[1], 1'b1);
        partner.press();
        st(4);
        test_fail <= 1'b0;
        $display("done: test and lockout");
        axw(ADDR_CTRL, 32'h2, RESP_OKAY);
        sync_ok <= 1'b0;
        partner.press();
        st(0);
        sync_ok <= 1'b1;
        st(2);
        axr(ADDR_IRQ_ST, rd, rs);
        exp_irq = 0;
        beam_clear <= ~(8'h01 << ($urandom % 8));
        st(0);
        beam_clear <= 8'hFF;
        st(2);
        axr(ADDR_IRQ_ST, rd, rs);
        chk(rd, exp_irq);
        // A blockage of a single cycle must still trip and then restart unaided.
        beam_clear <= ~(8'h01 << ($urandom % 8));
        @(posedge clk);
        beam_clear <= 8'hFF;
        #1 chk(outs, 1'b0);
        st(2);
        $display("done: automatic restart");
        results();
    end

    // Cuts a hang short well beyond the expected run length.
    initial
    begin
        repeat (20000) @(posedge clk);
        err_total++;
        results();
    end
endmodule
